// file: pkg/osc_prog_pkg.sv
/*
  constants for the oscillator frequency programming block: register
  offsets, field positions, decode masks, reset values and timing counts.
  assumes a 250 MHz system clock.
*/
package osc_prog_pkg;
  // =====================================================================
  // register offsets
  localparam logic [7:0] ctrl_word_low_addr = 8'h00;
  localparam logic [7:0] ctrl_word_high_addr = 8'h01;
  localparam logic [7:0] pull_range_select_addr = 8'h02;
  localparam logic [7:0] feedback_divider_high_addr = 8'h03;
  localparam logic [7:0] feedback_divider_low_addr = 8'h04;
  localparam logic [7:0] forward_divider_and_drive_high_addr = 8'h05;
  localparam logic [7:0] misc_and_drive_low_addr = 8'h06;

  // =====================================================================
  // field positions
  localparam int int_field_hi = 15;
  localparam int int_field_lo = 11;
  localparam int frac_top_hi = 10;
  localparam int fwd_field_hi = 15;
  localparam int fwd_field_lo = 3;
  localparam int drive_part_hi = 2;
  localparam int ctrl_high_hi = 9;
  localparam int pull_range_hi = 3;

  // =====================================================================
  // decode masks and reset values
  localparam logic [4:0] int_mask = 5'h0e;
  localparam logic [12:0] fwd_mask = 13'h001b;
  localparam logic [15:0] reg_reset = 16'h0000;
  localparam logic [3:0] factory_pull_range = 4'h6;
  // largest pull word magnitude, full scale of the selected range
  localparam logic signed [25:0] pull_full_scale = 26'h1ffffff;

  // pull step per range code, tenths of a part per trillion
  localparam logic [15:0] pull_step_table [16] = '{
    16'h0032, 16'h0032, 16'h0032, 16'h0032, 16'h0032, 16'h0032,
    16'h0032, 16'h0032, 16'h0032, 16'h0064, 16'h008c, 16'h00d2,
    16'h0140, 16'h01d6, 16'h03ac, 16'h03ac};

  // =====================================================================
  // timing
  localparam int clk_period_ns = 4;
  localparam int disable_time_ns = 2300;
  localparam int disable_cycles = disable_time_ns / clk_period_ns;
  localparam int settle_time_ns = 421000;
  localparam int settle_cycles = settle_time_ns / clk_period_ns;
  localparam int lock_stable_cycles = 256;
  localparam int pull_rate_hz = 38000;
  localparam int pull_gap_cycles =
    (1000000000 + pull_rate_hz * clk_period_ns - 1) /
    (pull_rate_hz * clk_period_ns);
endpackage

// file: rtl/relock_timer.sv
/*
  holds the output blanked after a divider change until the synthesizer
  reports lock for a stable interval, or the settle limit runs out.
  assumes pll_locked is synchronous to clk.
*/
`timescale 1ns/1ps
module relock_timer #(
  parameter int settle_limit = osc_prog_pkg::settle_cycles
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic pll_locked,
  output logic busy
);
  logic [16:0] settle_count;
  logic [8:0] stable_count;
  wire settle_done = settle_count == 17'(settle_limit - 1);
  wire stable_done = pll_locked &&
    stable_count == 9'(osc_prog_pkg::lock_stable_cycles - 1);

  // =====================================================================
  // blanking window
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      busy <= 1'b0;
      settle_count <= 17'h00000;
      stable_count <= 9'h000;
    end
    else if (start)
    begin
      busy <= 1'b1;
      settle_count <= 17'h00000;
      stable_count <= 9'h000;
    end
    else if (busy)
    begin
      settle_count <= settle_count + 17'h00001;
      stable_count <= pll_locked ? stable_count + 9'h001 : 9'h000;
      if (settle_done || stable_done)
        busy <= 1'b0;
    end
  end

  property p_settle_bound;
    @(posedge clk) disable iff (rst)
      busy |-> settle_count < 17'(settle_limit);
  endproperty
  a_settle_bound: assert property (p_settle_bound)
    else $error("blanking outlived settle limit");
endmodule // relock_timer

// file: rtl/osc_prog_ctrl.sv
/*
  control registers of a programmable oscillator: staged divider and
  drive words applied together, output blanking while the synthesizer
  re-locks, and a signed pull word limited to the selected range.
  assumes a register port decoded from the serial slave, one access per
  strobe, synchronous to clk.
*/
// Functional notes
// - low feedback field is an unsigned 27-bit fraction of N.
// - integer part of N is stored field XOR 01110b.
// - forward divider is 13 bits, stored XOR 0000000011011b.
// - drive bits 5:3 in forward_divider_and_drive_high[2:0], bits 2:0 in 0x06[2:0].
// - feedback_divider_high holds integer and top fraction, feedback_divider_low low fraction, forward_divider_and_drive_high M.
// - writing forward_divider_and_drive_high blanks the output until lock, then re-enables.
// - blanking within 2.3 us, settling done within 421 us.
// - pull mode starts at nominal frequency and factory range.
// - pull range is a 4-bit field in pull_range_select[3:0].
// - control word is signed two's complement, full scale is range.
// - pulled frequency never leaves the selected range.
// - step 5 ppt up to 200 ppm, about 94 ppt at 3200 ppm.
// - output frequency is 94 MHz times N over M.
// - low word before high word; updates at most 38 kHz.
`timescale 1ns/1ps
module osc_prog_ctrl #(
  parameter int settle_limit = osc_prog_pkg::settle_cycles,
  parameter int pull_gap = osc_prog_pkg::pull_gap_cycles
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_write_data,
  output logic [15:0] reg_read_data,
  input wire logic pll_locked,
  output logic [4:0] feedback_int,
  output logic [26:0] feedback_frac,
  output logic [12:0] forward_div,
  output logic [5:0] drive_setting,
  output logic synth_load,
  output logic clk_out_enable,
  output logic signed [25:0] pull_word,
  output logic [3:0] pull_range,
  output logic [15:0] pull_step,
  output logic pull_load
);
  // =====================================================================
  // register storage
  logic [15:0] ctrl_word_low;
  logic [15:0] ctrl_word_high;
  logic [15:0] pull_range_select;
  logic [15:0] feedback_divider_high;
  logic [15:0] feedback_divider_low;
  logic [15:0] forward_divider_and_drive_high;
  logic [15:0] misc_and_drive_low;
  logic pull_pending;
  logic [12:0] gap_count;
  logic relock_busy;

  function automatic logic signed [25:0] limit_pull(
    input logic signed [25:0] word);
    // the single code below negative full scale is pulled back inside
    if (word < -osc_prog_pkg::pull_full_scale)
      return -osc_prog_pkg::pull_full_scale;
    return word;
  endfunction

  // =====================================================================
  // decode
  wire wr_low = reg_write && reg_addr == osc_prog_pkg::ctrl_word_low_addr;
  wire wr_high = reg_write &&
    reg_addr == osc_prog_pkg::ctrl_word_high_addr;
  wire wr_range = reg_write &&
    reg_addr == osc_prog_pkg::pull_range_select_addr;
  wire wr_fb_high = reg_write &&
    reg_addr == osc_prog_pkg::feedback_divider_high_addr;
  wire wr_fb_low = reg_write &&
    reg_addr == osc_prog_pkg::feedback_divider_low_addr;
  wire wr_fwd = reg_write &&
    reg_addr == osc_prog_pkg::forward_divider_and_drive_high_addr;
  wire wr_misc = reg_write &&
    reg_addr == osc_prog_pkg::misc_and_drive_low_addr;
  wire gap_open = gap_count == 13'h0000;
  wire pull_fire = (wr_high || pull_pending) && gap_open;
  // staged word seen with the high part already written
  wire [15:0] next_high_word = wr_high ? reg_write_data : ctrl_word_high;
  wire signed [25:0] staged_pull = {
    next_high_word[osc_prog_pkg::ctrl_high_hi:0], ctrl_word_low};
  wire [4:0] stored_int = feedback_divider_high[
    osc_prog_pkg::int_field_hi:osc_prog_pkg::int_field_lo];
  wire [12:0] stored_fwd = reg_write_data[
    osc_prog_pkg::fwd_field_hi:osc_prog_pkg::fwd_field_lo];
  wire [2:0] drive_high_part =
    reg_write_data[osc_prog_pkg::drive_part_hi:0];
  wire [2:0] drive_low_part =
    misc_and_drive_low[osc_prog_pkg::drive_part_hi:0];

  // =====================================================================
  // register writes
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctrl_word_low <= osc_prog_pkg::reg_reset;
      ctrl_word_high <= osc_prog_pkg::reg_reset;
      pull_range_select <= {12'h000, osc_prog_pkg::factory_pull_range};
      feedback_divider_high <= osc_prog_pkg::reg_reset;
      feedback_divider_low <= osc_prog_pkg::reg_reset;
      forward_divider_and_drive_high <= osc_prog_pkg::reg_reset;
      misc_and_drive_low <= osc_prog_pkg::reg_reset;
    end
    else
    begin
      if (wr_low)
        ctrl_word_low <= reg_write_data;
      if (wr_high)
        ctrl_word_high <= reg_write_data;
      if (wr_range)
        pull_range_select <= reg_write_data;
      if (wr_fb_high)
        feedback_divider_high <= reg_write_data;
      if (wr_fb_low)
        feedback_divider_low <= reg_write_data;
      if (wr_fwd)
        forward_divider_and_drive_high <= reg_write_data;
      if (wr_misc)
        misc_and_drive_low <= reg_write_data;
    end
  end

  // =====================================================================
  // read back
  always_ff @(posedge clk)
  begin
    if (rst)
      reg_read_data <= 16'h0000;
    else if (reg_read)
    begin
      unique case (reg_addr)
        osc_prog_pkg::ctrl_word_low_addr:
          reg_read_data <= ctrl_word_low;
        osc_prog_pkg::ctrl_word_high_addr:
          reg_read_data <= ctrl_word_high;
        osc_prog_pkg::pull_range_select_addr:
          reg_read_data <= pull_range_select;
        osc_prog_pkg::feedback_divider_high_addr:
          reg_read_data <= feedback_divider_high;
        osc_prog_pkg::feedback_divider_low_addr:
          reg_read_data <= feedback_divider_low;
        osc_prog_pkg::forward_divider_and_drive_high_addr:
          reg_read_data <= forward_divider_and_drive_high;
        osc_prog_pkg::misc_and_drive_low_addr:
          reg_read_data <= misc_and_drive_low;
        default:
          reg_read_data <= 16'h0000;
      endcase
    end
  end

  // =====================================================================
  // synthesizer load, all staged values move together
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      feedback_int <= osc_prog_pkg::int_mask;
      feedback_frac <= 27'h0000000;
      forward_div <= osc_prog_pkg::fwd_mask;
      drive_setting <= 6'h00;
      synth_load <= 1'b0;
    end
    else
    begin
      synth_load <= wr_fwd;
      if (wr_fwd)
      begin
        feedback_int <= stored_int ^ osc_prog_pkg::int_mask;
        feedback_frac <= {feedback_divider_high[
          osc_prog_pkg::frac_top_hi:0], feedback_divider_low};
        forward_div <= stored_fwd ^ osc_prog_pkg::fwd_mask;
        drive_setting <= {drive_high_part, drive_low_part};
      end
    end
  end

  // =====================================================================
  // output blanking around a re-lock
  relock_timer #(
    .settle_limit(settle_limit)
  ) relock (
    .clk(clk),
    .rst(rst),
    .start(wr_fwd),
    .pll_locked(pll_locked),
    .busy(relock_busy)
  );

  always_ff @(posedge clk)
  begin
    if (rst)
      clk_out_enable <= 1'b1;
    else
      clk_out_enable <= !wr_fwd && !relock_busy;
  end

  // =====================================================================
  // pull word, applied whole and no faster than the update rate
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pull_word <= 26'sh0000000;
      pull_range <= osc_prog_pkg::factory_pull_range;
      pull_step <= osc_prog_pkg::pull_step_table[
        osc_prog_pkg::factory_pull_range];
      pull_load <= 1'b0;
      pull_pending <= 1'b0;
      gap_count <= 13'h0000;
    end
    else
    begin
      pull_load <= pull_fire;
      if (pull_fire)
      begin
        pull_word <= limit_pull(staged_pull);
        gap_count <= 13'(pull_gap - 1);
        pull_pending <= 1'b0;
      end
      else
      begin
        if (!gap_open)
          gap_count <= gap_count - 13'h0001;
        if (wr_high)
          pull_pending <= 1'b1;
      end
      pull_range <= pull_range_select[
        osc_prog_pkg::pull_range_hi:0];
      pull_step <= osc_prog_pkg::pull_step_table[
        pull_range_select[osc_prog_pkg::pull_range_hi:0]];
    end
  end

  // =====================================================================
  // checks
  property p_load_on_fwd;
    @(posedge clk) disable iff (rst) wr_fwd |=> synth_load;
  endproperty
  a_load_on_fwd: assert property (p_load_on_fwd)
    else $error("forward_divider_and_drive_high write did not load the synthesizer");

  property p_blank_fast;
    @(posedge clk) disable iff (rst) wr_fwd |=> !clk_out_enable;
  endproperty
  a_blank_fast: assert property (p_blank_fast)
    else $error("output not blanked after divider change");

  property p_reenable;
    @(posedge clk) disable iff (rst)
      (!clk_out_enable && !relock_busy && !wr_fwd) |=> clk_out_enable;
  endproperty
  a_reenable: assert property (p_reenable)
    else $error("output stayed blanked after lock");

  property p_int_decode;
    @(posedge clk) disable iff (rst)
      wr_fwd |=> feedback_int == ($past(stored_int) ^ 5'h0e);
  endproperty
  a_int_decode: assert property (p_int_decode)
    else $error("feedback integer decode wrong");

  property p_fwd_decode;
    @(posedge clk) disable iff (rst)
      wr_fwd |=> forward_div == ($past(stored_fwd) ^ 13'h001b);
  endproperty
  a_fwd_decode: assert property (p_fwd_decode)
    else $error("forward divider decode wrong");

  property p_drive_split;
    @(posedge clk) disable iff (rst)
      wr_fwd |=> drive_setting ==
        {$past(reg_write_data[2:0]), $past(misc_and_drive_low[2:0])};
  endproperty
  a_drive_split: assert property (p_drive_split)
    else $error("drive setting assembled wrongly");

  property p_stable_without_load;
    @(posedge clk) disable iff (rst)
      !wr_fwd |=> $stable(forward_div) && $stable(feedback_frac);
  endproperty
  a_stable_without_load: assert property (p_stable_without_load)
    else $error("divider changed without a forward_divider_and_drive_high write");

  property p_pull_limited;
    @(posedge clk) disable iff (rst)
      pull_word >= -osc_prog_pkg::pull_full_scale;
  endproperty
  a_pull_limited: assert property (p_pull_limited)
    else $error("pull word beyond range");

  property p_pull_needs_high;
    @(posedge clk) disable iff (rst)
      pull_load |-> $past(wr_high) || $past(pull_pending);
  endproperty
  a_pull_needs_high: assert property (p_pull_needs_high)
    else $error("pull applied without high word");

  property p_pull_rate;
    @(posedge clk) disable iff (rst)
      pull_load |=> !pull_load [*2];
  endproperty
  a_pull_rate: assert property (p_pull_rate)
    else $error("pull updates too close together");
endmodule // osc_prog_ctrl

// file: sim/reg_host_model.sv
/*
  host side model of the register port: single writes and reads, the
  staged divider sequence and the two-part pull word.
  assumes clk is the block clock; the bench calls its tasks.
*/
`timescale 1ns/1ps
module reg_host_model (
  input wire logic clk,
  output logic reg_write,
  output logic reg_read,
  output logic [7:0] reg_addr,
  output logic [15:0] reg_write_data,
  input wire logic [15:0] reg_read_data
);
  // =====================================================================
  // idle levels
  initial
  begin
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 8'h00;
    reg_write_data = 16'h0000;
  end

  // =====================================================================
  // single accesses
  task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_write_data <= d;
    @(posedge clk);
    reg_write <= 1'b0;
    // released data must not keep showing the last value
    reg_write_data <= ~d;
  endtask

  task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    reg_addr <= ~a;
    @(posedge clk);
    #1;
    d = reg_read_data;
  endtask

  // =====================================================================
  // sequences
  // cycles left between transactions, shortened for the bench
  localparam int spi_transaction_gap = 4;

  // stages the feedback words and low drive bits; forward_divider_and_drive_high is left to caller
  task automatic stage_freq(input logic [15:0] r3, input logic [15:0] r4,
                            input logic [2:0] drv_lo);
    logic [15:0] keep;
    read_reg(8'h06, keep);
    write_reg(8'h03, r3);
    repeat (spi_transaction_gap) @(posedge clk);
    write_reg(8'h04, r4);
    repeat (spi_transaction_gap) @(posedge clk);
    write_reg(8'h06, {keep[15:3], drv_lo});
    repeat (spi_transaction_gap) @(posedge clk);
  endtask

  task automatic write_pull(input logic [25:0] w);
    write_reg(8'h00, w[15:0]);
    write_reg(8'h01, {6'h00, w[25:16]});
  endtask
endmodule // reg_host_model

// file: sim/oscillator_frequency_programming_bench.sv
/*
  self-checking bench for osc_prog_ctrl: reset state, staged divider
  load, output blanking with and without lock, pull range and pull word.
  assumes short settle and pull gap parameters; pll_locked driven here.
*/
`timescale 1ns/1ps
module oscillator_frequency_programming_bench;
  logic clk, rst, pll_locked;
  logic reg_write, reg_read, synth_load, clk_out_enable, pull_load;
  logic [7:0] reg_addr;
  logic [15:0] reg_write_data, reg_read_data, pull_step, rd;
  logic [4:0] feedback_int;
  logic [26:0] feedback_frac;
  logic [12:0] forward_div;
  logic [5:0] drive_setting;
  logic signed [25:0] pull_word;
  logic [3:0] pull_range;
  int fail_count, compares;
  localparam logic [26:0] frac = 27'h482b94e;
  localparam logic [15:0] r3 = {5'h0d ^ osc_prog_pkg::int_mask, frac[26:16]};
  localparam logic [15:0] r5 = {13'h0011 ^ osc_prog_pkg::fwd_mask, 3'h6};
  localparam logic [15:0] steps [16] = '{16'h0032, 16'h0032, 16'h0032,
    16'h0032, 16'h0032, 16'h0032, 16'h0032, 16'h0032, 16'h0032, 16'h0064,
    16'h008c, 16'h00d2, 16'h0140, 16'h01d6, 16'h03ac, 16'h03ac};
  localparam logic signed [25:0] words [4] = '{26'h0e66666, 26'h2000000,
    26'h1ffffff, 26'h3800000};
  localparam logic signed [25:0] applied [4] = '{26'h0e66666, 26'h2000001,
    26'h1ffffff, 26'h3800000};

  osc_prog_ctrl #(.settle_limit(400), .pull_gap(4)) i_dut (
    .clk(clk), .rst(rst), .reg_write(reg_write), .reg_read(reg_read),
    .reg_addr(reg_addr), .reg_write_data(reg_write_data),
    .reg_read_data(reg_read_data), .pll_locked(pll_locked),
    .feedback_int(feedback_int), .feedback_frac(feedback_frac),
    .forward_div(forward_div), .drive_setting(drive_setting),
    .synth_load(synth_load), .clk_out_enable(clk_out_enable),
    .pull_word(pull_word), .pull_range(pull_range),
    .pull_step(pull_step), .pull_load(pull_load));

  reg_host_model i_host (
    .clk(clk), .reg_write(reg_write), .reg_read(reg_read),
    .reg_addr(reg_addr), .reg_write_data(reg_write_data),
    .reg_read_data(reg_read_data));

  // =====================================================================
  // checking helpers
  task automatic check(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  // sel 0 synth_load, 1 pull_load, 2 clk_out_enable
  task automatic wait_for(input string name, input int sel,
                          input logic lvl, input int n);
    logic s;
    for (int i = 0; i < n; i++)
    begin
      #1;
      s = sel == 0 ? synth_load : sel == 1 ? pull_load : clk_out_enable;
      if (s === lvl)
        break;
      @(posedge clk);
    end
    check(name, 32'(lvl), 32'(s));
  endtask

  task automatic conclude();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // =====================================================================
  // clock and watchdog
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    conclude();
  end

  // =====================================================================
  // tests
  initial
  begin
    rst = 1'b1;
    pll_locked = 1'b1;
    fail_count = 0;
    compares = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check("feedback_int", 32'h0e, 32'(feedback_int));
    check("forward_div", 32'h1b, 32'(forward_div));
    check("clk_out_enable", 32'h1, 32'(clk_out_enable));
    check("pull_range", 32'h6, 32'(pull_range));
    check("pull_word", 32'h0, 32'(pull_word));
    for (int k = 0; k < 8; k++)
    begin
      i_host.read_reg(8'(k), rd);
      check("reset read", k == 2 ? 32'h6 : 32'h0, 32'(rd));
    end
    // pull range codes and step sizes
    for (int k = 0; k < 16; k++)
    begin
      i_host.write_reg(8'h02, {12'habc, 4'(k)});
      repeat (2) @(posedge clk);
      #1;
      check("pull_range", 32'(k), 32'(pull_range));
      check("pull_step", 32'(steps[k]), 32'(pull_step));
    end
    i_host.read_reg(8'h02, rd);
    check("range readback", 32'habcf, 32'(rd));
    // staged divider words stay off the synthesizer until forward_divider_and_drive_high
    i_host.stage_freq(r3, frac[15:0], 3'h6);
    repeat (2) @(posedge clk);
    #1;
    check("staged int", 32'h0e, 32'(feedback_int));
    check("staged frac", 32'h0, 32'(feedback_frac));
    i_host.write_reg(8'h05, r5);
    wait_for("synth_load", 0, 1'b1, 4);
    check("feedback_int", 32'h0d, 32'(feedback_int));
    check("feedback_frac", 32'(frac), 32'(feedback_frac));
    check("forward_div", 32'h11, 32'(forward_div));
    check("drive", 32'h36, 32'(drive_setting));
    wait_for("blank", 2, 1'b0, osc_prog_pkg::disable_cycles);
    repeat (200) @(posedge clk);
    #1;
    check("blank held", 32'h0, 32'(clk_out_enable));
    wait_for("enable after lock", 2, 1'b1, 100);
    i_host.read_reg(8'h03, rd);
    check("readback 03", 32'(r3), 32'(rd));
    i_host.read_reg(8'h05, rd);
    check("readback 05", 32'(r5), 32'(rd));
    i_host.write_reg(8'h07, 16'h5a5a);
    i_host.read_reg(8'h07, rd);
    check("unmapped read", 32'h0, 32'(rd));
    // second change without lock ends at the settle limit
    @(posedge clk);
    pll_locked <= 1'b0;
    i_host.stage_freq(r3, frac[15:0], 3'h0);
    i_host.write_reg(8'h05, {13'h0002 ^ osc_prog_pkg::fwd_mask, 3'h1});
    wait_for("synth_load", 0, 1'b1, 4);
    check("forward_div", 32'h2, 32'(forward_div));
    check("drive", 32'h08, 32'(drive_setting));
    repeat (300) @(posedge clk);
    #1;
    check("blank unlocked", 32'h0, 32'(clk_out_enable));
    wait_for("enable at limit", 2, 1'b1, 150);
    @(posedge clk);
    pll_locked <= 1'b1;
    // low part alone must not move the pull word
    i_host.write_reg(8'h00, 16'h1234);
    repeat (4) @(posedge clk);
    #1;
    check("pull half", 32'h0, 32'(pull_word));
    // control words from offset over range times full scale
    for (int k = 0; k < 4; k++)
    begin
      i_host.write_pull(words[k]);
      wait_for("pull_load", 1, 1'b1, 10);
      check("pull", 32'(applied[k]), 32'(pull_word));
    end
    // a high write inside the gap waits for the gap to end
    i_host.write_reg(8'h01, 16'h0155);
    #1;
    check("pull gap", 32'h0, 32'(pull_load));
    wait_for("pull pending", 1, 1'b1, 10);
    check("pull late", 32'h01550000, 32'(pull_word));
    conclude();
  end
endmodule // oscillator_frequency_programming_bench
